// ===== rtl/vic_pkg.sv
// Package: vectors, priorities, stack depth and carrier types for the irq unit
package vic_pkg;

  localparam int VIC_NSRC = 5;
  localparam int VIC_PC_W = 12;
  localparam int VIC_STACK_DEPTH = 8;

  // Source indices, highest priority first
  localparam int VIC_SRC_EXT = 0;
  localparam int VIC_SRC_TMR0 = 1;
  localparam int VIC_SRC_TMR1 = 2;
  localparam int VIC_SRC_TBASE = 3;
  localparam int VIC_SRC_ADC = 4;

  // Vector addresses
  localparam logic [VIC_PC_W-1:0] VIC_VEC_EXT = 12'h004;
  localparam logic [VIC_PC_W-1:0] VIC_VEC_TMR0 = 12'h008;
  localparam logic [VIC_PC_W-1:0] VIC_VEC_TMR1 = 12'h00C;
  localparam logic [VIC_PC_W-1:0] VIC_VEC_TBASE = 12'h010;
  localparam logic [VIC_PC_W-1:0] VIC_VEC_ADC = 12'h014;

  // Position of the external flag in the first control register
  localparam int VIC_EXT_FLAG_BIT = 4;

  // Reset values
  localparam logic [VIC_NSRC-1:0] VIC_FLAGS_RST = 5'h00;
  localparam logic [VIC_NSRC-1:0] VIC_EN_RST = 5'h00;
  localparam logic VIC_GIE_RST = 1'b0;
  localparam logic [VIC_PC_W-1:0] VIC_PC_RST = 12'h000;
  localparam logic [3:0] VIC_SP_RST = 4'h0;

  // Phase-two pulse divider: instruction cycle is four system clocks
  localparam int VIC_PHASE_DIV = 4;

  typedef enum logic [1:0] {
    VIC_ST_IDLE = 2'b00,
    VIC_ST_PUSH = 2'b01,
    VIC_ST_LOAD = 2'b10
  } vic_state_t;

  // Software side of the control registers
  typedef struct packed {
    logic [VIC_NSRC-1:0] en;      // Per-source enables
    logic gie_set;                // Pulse: set global enable
    logic gie_clr;                // Pulse: clear global enable
    logic [VIC_NSRC-1:0] flag_clr; // Pulses: software flag clear
    logic [VIC_NSRC-1:0] flag_set; // Pulses: software flag set
  } vic_sw_t;

  // Request to the core sequencer
  typedef struct packed {
    logic valid;
    logic [VIC_PC_W-1:0] vector;
    logic [VIC_PC_W-1:0] ret_pc;
  } vic_call_t;

endpackage

// ===== rtl/vic_phase_div.sv
// Divider producing the one-cycle phase-two pulse
`timescale 1ns/1ps
module vic_phase_div
  import vic_pkg::*;
#(
  parameter int DIV = VIC_PHASE_DIV
)
(
  input wire logic clk,     // System clock
  input wire logic resetn,  // Async reset, active low
  output logic pulse_q      // One-cycle phase-two pulse
);

  logic [7:0] cnt_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q <= 8'h00;
      pulse_q <= 1'b0;
    end
    else if (cnt_q == 8'(DIV - 1))
    begin
      cnt_q <= 8'h00;
      pulse_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 8'h01;
      pulse_q <= 1'b0;
    end
  end

endmodule

// ===== rtl/vic_ctrl.sv
// Vectored interrupt controller: flags, priority, stack and shared pin
`timescale 1ns/1ps

// Behaviour
// - Enabled source events set their request flag
// - Accept: push next PC, load vector
// - Return pops saved PC and resumes
// - Acceptance clears global enable automatically
// - Blocked requests still set and hold flags
// - Software re-enable inside routine permits nesting
// - Full stack blocks acknowledge until pop
// - Requests sampled and serviced on phase-two pulse
// - Vectors 04H, 08H, 0CH for ext, timers
// - Vectors 10H time base, 14H conversion
// - Fixed priority external first, conversion last
// - Global enable low services nothing
// - Per-source enables gate servicing
// - External needs global and external enable
// - External flag set on both pin edges
// - Pin is irq input under three conditions
// - External enable clear: pin is CMOS output
// - Servicing external clears flag bit 4
// - Flags hold until serviced or cleared
// - Servicing internal source clears its flag
// - Any pending enabled source wakes processor
module vic_ctrl
  import vic_pkg::*;
#(
  parameter int STACK_DEPTH = VIC_STACK_DEPTH
)
(
  input wire logic clk,                       // System clock
  input wire logic resetn,                    // Async reset, active low
  input vic_sw_t sw,                          // Software control strobes
  input wire logic [VIC_NSRC-1:1] src_event,  // Internal event pulses
  input wire logic ext_pin_in,                // Shared pin level
  input wire logic lcd_drive_enable,          // LCD drive owns the pin
  input wire logic shared_out_pin,            // Port output latch bit
  input wire logic [VIC_PC_W-1:0] next_pc,    // Address of next instruction
  input wire logic return_from_irq,           // Pulse: return executed
  input wire logic call_push,                 // Pulse: core pushed a call
  input wire logic call_pop,                  // Pulse: core popped a return
  output vic_call_t call_q,                   // Vector load to the core
  output logic [VIC_PC_W-1:0] resume_pc_q,    // Popped PC on return
  output logic resume_q,                      // Pulse: load resume_pc_q
  output logic global_irq_enable_q,           // Global enable state
  output logic [VIC_NSRC-1:0] flags_q,        // Request flags
  output logic ext_pin_out_q,                 // Shared pin output level
  output logic ext_pin_oe_q,                  // Shared pin output enable
  output logic wake_q,                        // Wake from power-down
  output logic [3:0] stack_ptr_q              // Stack occupancy
);

  // ------------------------------------------------------------
  // Phase-two pulse
  // ------------------------------------------------------------
  logic phase_two_pulse;

  vic_phase_div #(
    .DIV(VIC_PHASE_DIV)
  ) i_vic_phase_div (
    .clk(clk),
    .resetn(resetn),
    .pulse_q(phase_two_pulse)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [VIC_PC_W-1:0] vic_vector(input logic [2:0] s);
    case (s)
      3'h0: vic_vector = VIC_VEC_EXT;
      3'h1: vic_vector = VIC_VEC_TMR0;
      3'h2: vic_vector = VIC_VEC_TMR1;
      3'h3: vic_vector = VIC_VEC_TBASE;
      default: vic_vector = VIC_VEC_ADC;
    endcase
  endfunction

  // Lowest index wins, so external always beats the internal ones
  function automatic logic [2:0] vic_pick(input logic [VIC_NSRC-1:0] r);
    vic_pick = 3'h0;
    for (int i = VIC_NSRC - 1; i >= 0; i--)
    begin
      if (r[i])
      begin
        vic_pick = 3'(i);
      end
    end
  endfunction

  // ------------------------------------------------------------
  // Shared pin and edge detection
  // ------------------------------------------------------------
  logic pin_is_irq;
  logic pin_prev_q;
  logic ext_edge;

  assign pin_is_irq = sw.en[VIC_SRC_EXT] && !lcd_drive_enable
                      && shared_out_pin;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_prev_q <= 1'b0;
    end
    else
    begin
      pin_prev_q <= ext_pin_in;
    end
  end

  // Edge only counts while the pin is an input; avoids self-triggering
  // on our own output transitions
  assign ext_edge = pin_is_irq && (pin_prev_q != ext_pin_in);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ext_pin_out_q <= 1'b0;
      ext_pin_oe_q <= 1'b0;
    end
    else
    begin
      ext_pin_out_q <= shared_out_pin;
      ext_pin_oe_q <= !sw.en[VIC_SRC_EXT];
    end
  end

  // ------------------------------------------------------------
  // Request flags
  // ------------------------------------------------------------
  logic [VIC_NSRC-1:0] raw_event;
  logic [VIC_NSRC-1:0] hw_set;
  logic [VIC_NSRC-1:0] svc_clr;
  logic accept;
  logic [2:0] pick;

  assign raw_event = {src_event, ext_edge};
  assign hw_set = raw_event & sw.en;

  always_comb
  begin
    svc_clr = '0;
    if (accept)
    begin
      svc_clr[pick] = 1'b1;
    end
  end

  // Set wins over any clear in the same cycle, so no event is lost;
  // flags ignore the global enable entirely
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      flags_q <= VIC_FLAGS_RST;
    end
    else
    begin
      flags_q <= (flags_q & ~(svc_clr | sw.flag_clr))
                 | hw_set | sw.flag_set;
    end
  end

  // ------------------------------------------------------------
  // Arbitration
  // ------------------------------------------------------------
  logic [VIC_NSRC-1:0] pending;
  logic stack_full;
  vic_state_t state_q;

  assign pending = flags_q & sw.en;
  assign stack_full = (stack_ptr_q >= 4'(STACK_DEPTH));
  assign pick = vic_pick(pending);

  // Sampling on the phase-two pulse only gathers everything that
  // arrived since the previous pulse
  assign accept = phase_two_pulse && global_irq_enable_q
                  && (|pending) && !stack_full
                  && (state_q == VIC_ST_IDLE);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      global_irq_enable_q <= VIC_GIE_RST;
    end
    else if (accept)
    begin
      global_irq_enable_q <= 1'b0;
    end
    else if (sw.gie_set)
    begin
      global_irq_enable_q <= 1'b1;
    end
    else if (sw.gie_clr)
    begin
      global_irq_enable_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wake_q <= 1'b0;
    end
    else
    begin
      wake_q <= |pending;
    end
  end

  // ------------------------------------------------------------
  // Call sequencer and stack
  // ------------------------------------------------------------
  logic [VIC_PC_W-1:0] stack_mem_q [STACK_DEPTH];
  logic [2:0] pick_q;
  logic push_irq;
  logic pop_irq;

  assign push_irq = (state_q == VIC_ST_PUSH);
  assign pop_irq = return_from_irq && (stack_ptr_q != VIC_SP_RST);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= VIC_ST_IDLE;
      pick_q <= 3'h0;
    end
    else
    begin
      case (state_q)
        VIC_ST_IDLE:
        begin
          if (accept)
          begin
            pick_q <= pick;
            state_q <= VIC_ST_PUSH;
          end
        end
        VIC_ST_PUSH:
        begin
          state_q <= VIC_ST_LOAD;
        end
        VIC_ST_LOAD:
        begin
          state_q <= VIC_ST_IDLE;
        end
        default:
        begin
          state_q <= VIC_ST_IDLE;
        end
      endcase
    end
  end

  // Stack is shared with ordinary calls; the core reports its own
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stack_ptr_q <= VIC_SP_RST;
    end
    else if ((push_irq || call_push) && !(pop_irq || call_pop))
    begin
      if (!stack_full)
      begin
        stack_ptr_q <= stack_ptr_q + 4'h1;
      end
    end
    else if ((pop_irq || call_pop) && !(push_irq || call_push))
    begin
      if (stack_ptr_q != VIC_SP_RST)
      begin
        stack_ptr_q <= stack_ptr_q - 4'h1;
      end
    end
  end

  // Push and pop in one cycle keep the pointer, so the top is replaced
  always_ff @(posedge clk)
  begin
    if ((push_irq || call_push) && (pop_irq || call_pop)
        && (stack_ptr_q != VIC_SP_RST))
    begin
      stack_mem_q[3'(stack_ptr_q - 4'h1)] <= next_pc;
    end
    else if (push_irq && !stack_full)
    begin
      stack_mem_q[stack_ptr_q[2:0]] <= next_pc;
    end
    else if (call_push && !stack_full)
    begin
      stack_mem_q[stack_ptr_q[2:0]] <= next_pc;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      call_q <= '0;
    end
    else if (push_irq)
    begin
      call_q.valid <= 1'b1;
      call_q.vector <= vic_vector(pick_q);
      call_q.ret_pc <= next_pc;
    end
    else
    begin
      call_q.valid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      resume_pc_q <= VIC_PC_RST;
      resume_q <= 1'b0;
    end
    else if (pop_irq)
    begin
      resume_pc_q <= stack_mem_q[3'(stack_ptr_q - 4'h1)];
      resume_q <= 1'b1;
    end
    else
    begin
      resume_q <= 1'b0;
    end
  end

endmodule

// ===== tb/vic_ctrl_props.sv
// Checker of the interrupt controller port relations
`timescale 1ns/1ps
module vic_ctrl_props
  import vic_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic resetn, // Reset
  input vic_sw_t sw, // Controls
  input wire logic [VIC_NSRC-1:1] src_event, // Events
  input wire logic ext_pin_in, // Pin
  input wire logic lcd_drive_enable, // LCD owns pin
  input wire logic shared_out_pin, // Port bit
  input wire logic return_from_irq, // Return
  input vic_call_t call_q, // Call
  input wire logic resume_q, // Resume
  input wire logic global_irq_enable_q, // Enable
  input wire logic [VIC_NSRC-1:0] flags_q, // Flags
  input wire logic ext_pin_oe_q, // Pin drive
  input wire logic [3:0] stack_ptr_q // Stack
);
  logic [4:1] hit;
  logic [4:0] keep;
  logic ext_off;
  assign hit = src_event & sw.en[4:1];
  assign keep = flags_q & ~sw.flag_clr;
  assign ext_off = lcd_drive_enable | ~shared_out_pin | ~sw.en[0];
  // Lowest set bit: the highest priority pending source
  function automatic logic [4:0] low(logic [4:0] p);
    return p & (~p + 5'h01);
  endfunction
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----
  // Assertions
  // ----
  gie_gate_a: assert property (
    call_q.valid |-> $past(global_irq_enable_q, 2))
    else $error("call while disabled");
  vec_set_a: assert property (
    call_q.valid |-> call_q.vector inside {12'h004, 12'h008,
      12'h00C, 12'h010, 12'h014}) else $error("bad vector");
  full_stack_a: assert property (
    call_q.valid |-> $past(stack_ptr_q, 2) != 4'h8)
    else $error("call on full stack");
  prio_clear_a: assert property (
    $fell(global_irq_enable_q) && !$past(sw.gie_clr) |->
      ($past(flags_q) & ~flags_q) == low($past(flags_q & sw.en)))
    else $error("wrong flag cleared");
  ret_pop_a: assert property (
    return_from_irq && stack_ptr_q != 4'h0 |=> resume_q)
    else $error("return not resumed");
  pin_oe_a: assert property (
    !sw.en[0] ##1 !sw.en[0] |-> ext_pin_oe_q)
    else $error("pin not driven");
  ext_edge_a: assert property (
    $changed(ext_pin_in) && !ext_off |=> flags_q[0])
    else $error("pin edge missed");
  no_edge_a: assert property (
    !flags_q[0] && !sw.flag_set[0] && ext_off |=> !flags_q[0])
    else $error("flag set outside irq mode");
  ev_set_a: assert property (
    |hit && !global_irq_enable_q |=>
      (flags_q[4:1] & $past(hit)) == $past(hit))
    else $error("event not latched");
  flag_hold_a: assert property (
    !global_irq_enable_q |=> (flags_q & $past(keep)) == $past(keep))
    else $error("flag lost");
  cover property (call_q.valid);
  cover property (resume_q);
  cover property ($rose(flags_q[0]));
endmodule
bind vic_ctrl vic_ctrl_props i_vic_ctrl_props (.*);

// ===== tb/vic_core_model.sv
// Core sequencer model facing the controller
`timescale 1ns/1ps
module vic_core_model
  import vic_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic resetn, // Reset
  input vic_call_t call_q, // Vector call
  input wire logic resume_q, // Resume strobe
  input wire logic [VIC_PC_W-1:0] resume_pc_q, // Resume address
  input wire logic ret_req, // Bench asks for a return
  output logic [VIC_PC_W-1:0] next_pc, // Next fetch address
  output logic return_from_irq // Return executed
);
  // ----
  // Fetch counter
  // ----
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      next_pc <= 12'h100;
    else if (call_q.valid)
      next_pc <= call_q.vector + 12'h001;
    else if (resume_q)
      next_pc <= resume_pc_q;
    else
      next_pc <= next_pc + 12'h001;
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      return_from_irq <= 1'b0;
    else
      return_from_irq <= ret_req;
  end
endmodule

// ===== tb/vectored_irq_controller_test.sv
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
module vectored_irq_controller_test;
  import vic_pkg::*;
  logic clk, resetn, ext_pin_in, lcd_drive_enable, shared_out_pin;
  logic call_push, call_pop, ret_req, return_from_irq, resume_q;
  logic global_irq_enable_q, ext_pin_out_q, ext_pin_oe_q, wake_q;
  logic [4:1] src_event;
  logic [4:0] flags_q;
  logic [11:0] next_pc, resume_pc_q;
  logic [3:0] stack_ptr_q;
  logic [11:0] pcs [5];
  vic_sw_t sw;
  vic_call_t call_q, got;
  int failures = 0;
  int checks_done = 0;
  int waited;
  logic [11:0] pc_prev;
  vic_ctrl i_vic_ctrl (.*);
  vic_core_model i_vic_core_model (.*);
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----
  // Helpers
  // ----
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(string what, logic [11:0] seen, logic [11:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Raise flags and global enable, then wait up to 12 cycles for a vector call
  task automatic go(logic [4:0] fs);
    sw.flag_set = fs;
    sw.gie_set = 1'b1;
    tick();
    sw.flag_set = 5'h00;
    sw.gie_set = 1'b0;
    got = '0;
    waited = 99;
    for (int n = 0; n < 12 && !got.valid; n++)
    begin
      pc_prev = next_pc;
      tick();
      if (call_q.valid === 1'b1)
      begin
        got = call_q;
        waited = n + 1;
      end
    end
  endtask
  task automatic do_ret(logic [11:0] pc);
    ret_req = 1'b1;
    tick();
    ret_req = 1'b0;
    tick();
    chk("resume", 12'(resume_q), 12'h001);
    chk("resume_pc", resume_pc_q, pc);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_vec();
    for (int i = 0; i < 5; i++)
    begin
      sw.en = 5'h01 << i;
      go(5'h01 << i);
      chk("vector", got.vector, 12'h004 + 12'(4 * i));
      chk("flags", 12'(flags_q), 12'h000);
      chk("gie", 12'(global_irq_enable_q), 12'h000);
      chk("sp", 12'(stack_ptr_q), 12'h001);
      chk("ret_pc", got.ret_pc, pc_prev);
      chk("wait", 12'(waited <= VIC_PHASE_DIV + 1), 12'h001);
      do_ret(got.ret_pc);
    end
    $display("test vec done");
  endtask
  task automatic t_nest();
    sw.en = 5'h1F;
    src_event = 4'hF;
    ext_pin_in = 1'b1;
    tick();
    src_event = 4'h0;
    tick();
    chk("pend", 12'(flags_q), 12'h01F);
    chk("wake", 12'(wake_q), 12'h001);
    for (int i = 0; i < 5; i++)
    begin
      go(5'h00);
      pcs[i] = got.ret_pc;
      chk("nest", got.vector, 12'h004 + 12'(4 * i));
      chk("left", 12'(flags_q), 12'(5'h1E << i) & 12'h01F);
    end
    for (int i = 4; i >= 0; i--)
      do_ret(pcs[i]);
    chk("sp_empty", 12'(stack_ptr_q), 12'h000);
    $display("test nest done");
  endtask
  task automatic t_mask();
    sw.en = 5'h00;
    src_event = 4'hF;
    tick();
    src_event = 4'h0;
    chk("dropped", 12'(flags_q), 12'h000);
    go(5'h1F);
    chk("masked", 12'(got.valid), 12'h000);
    chk("no_wake", 12'(wake_q), 12'h000);
    sw.gie_clr = 1'b1;
    tick();
    sw.gie_clr = 1'b0;
    sw.en = 5'h1F;
    tick(12);
    chk("held", 12'(flags_q), 12'h01F);
    sw.flag_clr = 5'h1D;
    tick();
    sw.flag_clr = 5'h00;
    chk("sw_clr", 12'(flags_q), 12'h002);
    $display("test mask done");
  endtask
  task automatic t_full();
    call_push = 1'b1;
    tick(8);
    call_push = 1'b0;
    go(5'h00);
    chk("full", 12'(got.valid), 12'h000);
    call_pop = 1'b1;
    tick();
    call_pop = 1'b0;
    got = '0;
    go(5'h00);
    chk("popped", got.vector, 12'h008);
    $display("test full done");
  endtask
  task automatic t_pin();
    sw.en = 5'h00;
    tick(2);
    chk("oe_out", 12'(ext_pin_oe_q), 12'h001);
    chk("pin_lvl", 12'(ext_pin_out_q), 12'h001);
    shared_out_pin = 1'b0;
    tick(2);
    chk("pin_low", 12'(ext_pin_out_q), 12'h000);
    shared_out_pin = 1'b1;
    sw.en = 5'h01;
    lcd_drive_enable = 1'b1;
    tick(2);
    chk("oe_irq", 12'(ext_pin_oe_q), 12'h000);
    ext_pin_in = 1'b0;
    tick(2);
    chk("lcd_blk", 12'(flags_q[0]), 12'h000);
    lcd_drive_enable = 1'b0;
    shared_out_pin = 1'b0;
    tick();
    ext_pin_in = 1'b1;
    tick(2);
    chk("port_blk", 12'(flags_q[0]), 12'h000);
    shared_out_pin = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      tick();
      ext_pin_in = ~ext_pin_in;
      tick(2);
      chk("edge", 12'(flags_q[0]), 12'h001);
      sw.flag_clr = 5'h01;
      tick();
      sw.flag_clr = 5'h00;
    end
    $display("test pin done");
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    resetn = 1'b0;
    sw = '0;
    src_event = 4'h0;
    ext_pin_in = 1'b0;
    lcd_drive_enable = 1'b0;
    shared_out_pin = 1'b1;
    call_push = 1'b0;
    call_pop = 1'b0;
    ret_req = 1'b0;
    tick(3);
    resetn = 1'b1;
    tick();
    t_vec();
    t_nest();
    t_mask();
    t_full();
    t_pin();
    wrap_up();
  end
  // Whole run is under two hundred cycles
  initial
  begin
    #20000;
    failures++;
    wrap_up();
  end
endmodule
